//--- hpcl_pkg.sv
// Package for the hub port change and line status block.
// Assumes one clock, synchronous active-low reset and an Avalon-MM slave.
// Notes on behaviour
// - Requests never set enable change; hardware only.
// - Enable change reads one; firmware clears it.
// - Ports 1-3 set on disable; port 4 at EOF2.
// - Connect change reads one; firmware clears it.
// - Ports 1-3 set connect change at EOF2.
// - Port 4 connect change at EOF2 after reset.
// - Upper eleven bits of reply word zero.
// - Ports 1-3 bit 7 samples D+ at EOF2.
// - Port 4 D+ bit reads constant one.
// - Bit 3 holds D- from last frame end.
// - Ports 1-3 sample D- at EOF2; port 4 zero.
package hpcl_pkg;
	localparam int          HPCL_NPORTS        = 4;
	localparam int          HPCL_EMB_PORT      = 3;
	localparam logic [3:0]  HPCL_ADDR_CHANGE   = 4'h0;
	localparam logic [3:0]  HPCL_ADDR_LINE     = 4'h4;
	localparam logic [3:0]  HPCL_ADDR_REPLY    = 4'h8;
	localparam int          HPCL_BIT_CONCHG    = 0;
	localparam int          HPCL_BIT_ENCHG     = 1;
	localparam int          HPCL_BIT_DM        = 3;
	localparam int          HPCL_BIT_DP        = 7;
	localparam int          HPCL_REPLY_LSB     = 16;
	localparam logic [7:0]  HPCL_LINE_RESET    = 8'h00;
	localparam logic [31:0] HPCL_BAD_READ      = 32'h00000000;

	typedef struct packed {
		logic enable_change;
		logic connect_change;
		logic dplus;
		logic dminus;
	} hpcl_port_t;

	typedef struct packed {
		hpcl_port_t [HPCL_NPORTS-1:0] port;
		logic                         emb_reset_pending;
		logic [2:0]                   con_seen;
		logic                         emb_seen;
		logic [31:0]                  readdata;
		logic                         waitrequest;
		logic                         ack;
	} hpcl_state_t;
endpackage : hpcl_pkg

//--- hpcl_port_events.sv
// Per-port event detector: one cycle pulses for disable and connect changes.
// Assumes enable and connect levels synchronous to core_clk.
`timescale 1ns/1ns
module hpcl_port_events
	import hpcl_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic hw_enabled,
	input  wire logic hw_connected,
	output logic      disabled_pulse,
	output logic      connect_toggled
);
	typedef struct packed {
		logic en_q;
		logic con_q;
	} hpcl_ev_t;

	hpcl_ev_t st;
	hpcl_ev_t next_st;

	always_comb begin
		next_st.en_q  = hw_enabled;
		next_st.con_q = hw_connected;
	end

	// History follows the pins in reset too, so no false edge after release
	always_ff @(posedge core_clk) begin
		st <= next_st;
	end

	// Hardware-driven disable only; a request path has no input here
	assign disabled_pulse  = st.en_q & ~hw_enabled & resetn;
	assign connect_toggled = (st.con_q ^ hw_connected) & resetn;
endmodule : hpcl_port_events

//--- hpcl_top.sv
// Hub port change flags and line status registers, Avalon-MM slave.
// Assumes synchronous inputs and a one-cycle EOF2 strobe from the frame timer.
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module hpcl_top
	import hpcl_pkg::*;
#(
	parameter int NPORTS = HPCL_NPORTS
)
(
	input  wire logic              core_clk,
	input  wire logic              resetn,
	input  wire logic [3:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              eof2_strobe,
	input  wire logic              hub_reset_done,
	input  wire logic [2:0]        port_enabled,
	input  wire logic [2:0]        port_connected,
	input  wire logic [2:0]        port_dplus,
	input  wire logic [2:0]        port_dminus,
	input  wire logic              emb_hw_event,
	output logic      [NPORTS-1:0] port_enable_change_flag,
	output logic      [NPORTS-1:0] port_connect_change_flag,
	output logic      [NPORTS-1:0] dplus_line_level,
	output logic      [NPORTS-1:0] dminus_line_level
);
	hpcl_state_t st;
	hpcl_state_t next_st;
	logic [2:0]  dis_pulse;
	logic [2:0]  con_pulse;
	logic [2:0]  next_con_seen;
	logic        next_emb_seen;
	logic [1:0]  sel;
	logic [3:0]  clr_en;
	logic [3:0]  clr_con;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ev
			hpcl_port_events u_ev (
				.core_clk        (core_clk),
				.resetn          (resetn),
				.hw_enabled      (port_enabled[g]),
				.hw_connected    (port_connected[g]),
				.disabled_pulse  (dis_pulse[g]),
				.connect_toggled (con_pulse[g])
			);
		end
	endgenerate

	function automatic logic [7:0] change_byte(input hpcl_port_t p);
		logic [7:0] b;
		b = 8'h00;
		b[HPCL_BIT_CONCHG] = p.connect_change;
		b[HPCL_BIT_ENCHG]  = p.enable_change;
		return b;
	endfunction : change_byte

	function automatic logic [7:0] line_byte(input hpcl_port_t p);
		logic [7:0] b;
		b = HPCL_LINE_RESET;
		b[HPCL_BIT_DP] = p.dplus;
		b[HPCL_BIT_DM] = p.dminus;
		return b;
	endfunction : line_byte

	// Clears land on the answer edge; byte n clears port n where written one
	always_comb begin
		clr_en  = '0;
		clr_con = '0;
		if (st.ack == 1'b1 && avs_write && avs_address == HPCL_ADDR_CHANGE) begin
			for (int i = 0; i < 4; i++) begin
				if (avs_byteenable[i]) begin
					clr_en[i]  = avs_writedata[8*i+HPCL_BIT_ENCHG];
					clr_con[i] = avs_writedata[8*i+HPCL_BIT_CONCHG];
				end
			end
		end
	end

	always_comb begin
		next_st       = st;
		next_con_seen = st.con_seen | con_pulse;
		next_emb_seen = st.emb_seen | emb_hw_event;
		sel           = avs_writedata[1:0];
		if (hub_reset_done) begin
			next_st.emb_reset_pending = 1'b1;
		end
		for (int i = 0; i < 3; i++) begin
			if (clr_en[i]) begin
				next_st.port[i].enable_change = 1'b0;
			end
			if (clr_con[i]) begin
				next_st.port[i].connect_change = 1'b0;
			end
			// Set wins over a clear in the same cycle
			if (dis_pulse[i]) begin
				next_st.port[i].enable_change = 1'b1;
			end
			if (eof2_strobe) begin
				if (next_con_seen[i]) begin
					next_st.port[i].connect_change = 1'b1;
				end
				next_st.port[i].dplus  = port_dplus[i];
				next_st.port[i].dminus = port_dminus[i];
			end
		end
		if (eof2_strobe) begin
			next_con_seen = '0;
		end
		if (clr_en[HPCL_EMB_PORT]) begin
			next_st.port[HPCL_EMB_PORT].enable_change = 1'b0;
		end
		if (clr_con[HPCL_EMB_PORT]) begin
			next_st.port[HPCL_EMB_PORT].connect_change = 1'b0;
		end
		if (eof2_strobe) begin
			if (next_emb_seen) begin
				next_st.port[HPCL_EMB_PORT].enable_change = 1'b1;
			end
			next_emb_seen = 1'b0;
			if (st.emb_reset_pending || hub_reset_done) begin
				next_st.port[HPCL_EMB_PORT].connect_change = 1'b1;
				next_st.emb_reset_pending = 1'b0;
			end
		end
		next_st.port[HPCL_EMB_PORT].dplus  = 1'b1;
		next_st.port[HPCL_EMB_PORT].dminus = 1'b0;
		next_st.con_seen = next_con_seen;
		next_st.emb_seen = next_emb_seen;

		// Bus: one wait cycle, then answer
		next_st.ack         = 1'b0;
		next_st.waitrequest = 1'b1;
		if ((avs_read || avs_write) && !st.ack) begin
			next_st.ack         = 1'b1;
			next_st.waitrequest = 1'b0;
			next_st.readdata    = HPCL_BAD_READ;
			if (avs_read) begin
				if (avs_address == HPCL_ADDR_CHANGE) begin
					for (int i = 0; i < 4; i++) begin
						next_st.readdata[8*i +: 8] = change_byte(st.port[i]);
					end
				end else if (avs_address == HPCL_ADDR_LINE) begin
					for (int i = 0; i < 4; i++) begin
						next_st.readdata[8*i +: 8] = line_byte(st.port[i]);
					end
				end else if (avs_address == HPCL_ADDR_REPLY) begin
					// Upper half: change word, top eleven bits zero
					next_st.readdata[HPCL_REPLY_LSB +: 8] = change_byte(st.port[sel]);
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			st                                 <= '0;
			st.waitrequest                     <= 1'b1;
			st.port[HPCL_EMB_PORT].dplus       <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		avs_readdata    = st.readdata;
		avs_waitrequest = st.waitrequest;
		for (int i = 0; i < NPORTS; i++) begin
			port_enable_change_flag[i]  = st.port[i].enable_change;
			port_connect_change_flag[i] = st.port[i].connect_change;
			dplus_line_level[i]         = st.port[i].dplus;
			dminus_line_level[i]        = st.port[i].dminus;
		end
	end

	property p_emb_dplus;
		@(posedge core_clk) disable iff (!resetn)
		dplus_line_level[HPCL_EMB_PORT] && !dminus_line_level[HPCL_EMB_PORT];
	endproperty
	a_emb_dplus: assert property (p_emb_dplus) else $error("embedded line bits wrong");

	property p_dp_sample;
		@(posedge core_clk) disable iff (!resetn)
		eof2_strobe |=> dplus_line_level[0] == $past(port_dplus[0]);
	endproperty
	a_dp_sample: assert property (p_dp_sample) else $error("D+ not sampled");

	property p_dm_hold;
		@(posedge core_clk) disable iff (!resetn)
		!eof2_strobe |=> $stable(dminus_line_level[0]);
	endproperty
	a_dm_hold: assert property (p_dm_hold) else $error("D- changed off EOF2");

	property p_dis_set;
		@(posedge core_clk) disable iff (!resetn)
		dis_pulse[0] |=> port_enable_change_flag[0];
	endproperty
	a_dis_set: assert property (p_dis_set) else $error("enable change not set");

	property p_con_eof;
		@(posedge core_clk) disable iff (!resetn)
		!eof2_strobe && !port_connect_change_flag[1] |=> !port_connect_change_flag[1];
	endproperty
	a_con_eof: assert property (p_con_eof) else $error("connect flag off EOF2");

	property p_rst_con;
		@(posedge core_clk) disable iff (!resetn)
		hub_reset_done ##0 eof2_strobe |=> port_connect_change_flag[HPCL_EMB_PORT];
	endproperty
	a_rst_con: assert property (p_rst_con) else $error("port 4 connect missing");

	property p_reply_zero;
		@(posedge core_clk) disable iff (!resetn)
		!avs_waitrequest |-> avs_readdata[31:21] == 11'h000 || $past(avs_address) != HPCL_ADDR_REPLY;
	endproperty
	a_reply_zero: assert property (p_reply_zero) else $error("reply upper bits set");

	sequence s_clear_en;
		avs_write && !avs_waitrequest && avs_address == HPCL_ADDR_CHANGE;
	endsequence
	property p_clear_en;
		@(posedge core_clk) disable iff (!resetn)
		s_clear_en ##0 avs_byteenable[2] && avs_writedata[8 * 2 + HPCL_BIT_ENCHG] && !dis_pulse[2]
			|=> !port_enable_change_flag[2];
	endproperty
	a_clear_en: assert property (p_clear_en) else $error("clear lost");

	property p_emb_en;
		@(posedge core_clk) disable iff (!resetn)
		!eof2_strobe && !port_enable_change_flag[HPCL_EMB_PORT]
			|=> !port_enable_change_flag[HPCL_EMB_PORT];
	endproperty
	a_emb_en: assert property (p_emb_en) else $error("port 4 enable off EOF2");

	sequence s_rst_gap;
		(hub_reset_done && !eof2_strobe) ##1 (!eof2_strobe)[*4] ##1 eof2_strobe;
	endsequence
	property p_rst_seq;
		@(posedge core_clk) disable iff (!resetn)
		s_rst_gap |=> port_connect_change_flag[HPCL_EMB_PORT];
	endproperty
	a_rst_seq: assert property (p_rst_seq) else $error("port 4 connect late");

	sequence s_emb_gap;
		(emb_hw_event && !eof2_strobe) ##1 (!eof2_strobe)[*4] ##1 eof2_strobe;
	endsequence
	property p_emb_set;
		@(posedge core_clk) disable iff (!resetn)
		s_emb_gap |=> port_enable_change_flag[HPCL_EMB_PORT];
	endproperty
	a_emb_set: assert property (p_emb_set) else $error("port 4 enable not set");

	sequence s_con_gap;
		($changed(port_connected[0]) && !eof2_strobe) ##1 (!eof2_strobe)[*4] ##1 eof2_strobe;
	endsequence
	property p_con_set;
		@(posedge core_clk) disable iff (!resetn)
		s_con_gap |=> port_connect_change_flag[0];
	endproperty
	a_con_set: assert property (p_con_set) else $error("connect change not set");

	property p_dm_sample;
		@(posedge core_clk) disable iff (!resetn)
		eof2_strobe |=> dminus_line_level[1] == $past(port_dminus[1]);
	endproperty
	a_dm_sample: assert property (p_dm_sample) else $error("D- not sampled");

	property p_no_req_set;
		@(posedge core_clk) disable iff (!resetn)
		!dis_pulse[1] && !port_enable_change_flag[1] |=> !port_enable_change_flag[1];
	endproperty
	a_no_req_set: assert property (p_no_req_set) else $error("enable change set by request");

	sequence s_clear_con;
		avs_write && !avs_waitrequest && avs_address == HPCL_ADDR_CHANGE
			&& avs_byteenable[0] && avs_writedata[HPCL_BIT_CONCHG];
	endsequence
	property p_clear_con;
		@(posedge core_clk) disable iff (!resetn)
		s_clear_con ##0 !eof2_strobe |=> !port_connect_change_flag[0];
	endproperty
	a_clear_con: assert property (p_clear_con) else $error("connect clear lost");

	property p_con_emb_hold;
		@(posedge core_clk) disable iff (!resetn)
		!eof2_strobe && !port_connect_change_flag[HPCL_EMB_PORT]
			|=> !port_connect_change_flag[HPCL_EMB_PORT];
	endproperty
	a_con_emb_hold: assert property (p_con_emb_hold) else $error("port 4 connect off EOF2");

	property p_dp_hold;
		@(posedge core_clk) disable iff (!resetn)
		!eof2_strobe |=> $stable(dplus_line_level[2]);
	endproperty
	a_dp_hold: assert property (p_dp_hold) else $error("D+ changed off EOF2");

	property p_dis_set2;
		@(posedge core_clk) disable iff (!resetn)
		dis_pulse[2] |=> port_enable_change_flag[2];
	endproperty
	a_dis_set2: assert property (p_dis_set2) else $error("port 3 enable change not set");
endmodule : hpcl_top

//--- hpcl_far_side.sv
// Far-side model: frame timer strobe and downstream line levels.
// Assumes the bench asks for a frame end with a one-cycle request.
`timescale 1ns/1ns
module hpcl_far_side
	import hpcl_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       frame_end_req,
	output logic            eof2_strobe,
	output logic [2:0]      port_dplus,
	output logic [2:0]      port_dminus
);
	logic [5:0] lines;

	// Lines change every cycle, so only the strobe cycle holds the sampled value
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			lines <= 6'h15;
		end else begin
			lines <= {lines[4:0], ~(lines[5] ^ lines[4])};
		end
		eof2_strobe <= frame_end_req & resetn & ~eof2_strobe;
	end

	assign port_dplus  = lines[2:0];
	assign port_dminus = lines[5:3];
endmodule : hpcl_far_side

//--- tb_top.sv
// Testbench for the hub port change and line status block.
// Assumes the far-side model drives frame ends and line levels.
`timescale 1ns/1ns
module tb_top
	import hpcl_pkg::*;
;
	logic        core_clk, resetn, avs_read, avs_write, avs_waitrequest;
	logic [3:0]  avs_address, avs_byteenable, exp_en, exp_con, exp_dp, exp_dm;
	logic [31:0] avs_writedata, avs_readdata, rd, wd, r, seed;
	logic        eof2_strobe, hub_reset_done, emb_hw_event, frame_end_req;
	logic [2:0]  port_enabled, port_connected, port_dplus, port_dminus;
	logic [2:0]  prev_en, prev_con, con_seen;
	logic        emb_seen, rst_seen;
	logic [3:0]  f_en, f_con, f_dp, f_dm;
	int          n_mismatch, checks;

	hpcl_top dut (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .eof2_strobe(eof2_strobe),
		.hub_reset_done(hub_reset_done), .port_enabled(port_enabled),
		.port_connected(port_connected), .port_dplus(port_dplus),
		.port_dminus(port_dminus), .emb_hw_event(emb_hw_event),
		.port_enable_change_flag(f_en), .port_connect_change_flag(f_con),
		.dplus_line_level(f_dp), .dminus_line_level(f_dm));

	hpcl_far_side far (.core_clk(core_clk), .resetn(resetn), .frame_end_req(frame_end_req),
		.eof2_strobe(eof2_strobe), .port_dplus(port_dplus), .port_dminus(port_dminus));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic logic [31:0] chg_word();
		logic [31:0] w;
		for (int p = 0; p < 4; p++) w[8*p+:8] = {6'h00, exp_en[p], exp_con[p]};
		return w;
	endfunction : chg_word

	function automatic logic [31:0] line_word();
		logic [31:0] w;
		for (int p = 0; p < 4; p++) w[8*p+:8] = {exp_dp[p], 3'h0, exp_dm[p], 3'h0};
		return w;
	endfunction : line_word

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge core_clk);
		avs_address    <= a;
		avs_writedata  <= d;
		avs_byteenable <= be;
		avs_read       <= ~wr;
		avs_write      <= wr;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic final_report();
		if (n_mismatch == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report

	// Reference model of the flags, from the inputs seen at each edge
	always @(posedge core_clk) begin
		if (!resetn) begin
			{exp_en, exp_con, exp_dm, con_seen, emb_seen, rst_seen} = '0;
			exp_dp = 4'h8;
		end else begin
			exp_en[2:0] = exp_en[2:0] | (prev_en & ~port_enabled);
			con_seen = con_seen | (prev_con ^ port_connected);
			emb_seen = emb_seen | emb_hw_event;
			rst_seen = rst_seen | hub_reset_done;
			if (eof2_strobe) begin
				exp_con = exp_con | {rst_seen, con_seen};
				exp_en[3] = exp_en[3] | emb_seen;
				exp_dp = {1'b1, port_dplus};
				exp_dm = {1'b0, port_dminus};
				{con_seen, emb_seen, rst_seen} = '0;
			end
		end
		prev_en = port_enabled;
		prev_con = port_connected;
	end

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		final_report();
	end

	initial begin
		seed = 32'hF457BA7C;
		{resetn, avs_read, avs_write, hub_reset_done, emb_hw_event, frame_end_req} = '0;
		{avs_address, avs_byteenable, avs_writedata, port_connected} = '0;
		port_enabled = 3'h7;
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		check({16'h0000, f_en, f_con, f_dp, f_dm}, 32'h00000080);
		bus(1'b0, HPCL_ADDR_LINE, 32'h0, 4'hF);
		check(rd, line_word());
		bus(1'b1, HPCL_ADDR_LINE, 32'hFFFFFFFF, 4'hF);
		bus(1'b0, HPCL_ADDR_LINE, 32'h0, 4'hF);
		check(rd, line_word());
		bus(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
		bus(1'b0, 4'hC, 32'h0, 4'hF);
		check(rd, 32'h00000000);
		for (int i = 0; i < 24; i++) begin
			r = rnd();
			@(posedge core_clk);
			port_enabled   <= r[2:0];
			port_connected <= r[5:3];
			emb_hw_event   <= r[6];
			hub_reset_done <= r[7] & i[0];
			@(posedge core_clk);
			emb_hw_event   <= 1'b0;
			hub_reset_done <= 1'b0;
			repeat (3) @(posedge core_clk);
			frame_end_req <= r[8] | (i < 4);
			@(posedge core_clk);
			frame_end_req  <= 1'b0;
			hub_reset_done <= r[11];
			@(posedge core_clk);
			hub_reset_done <= 1'b0;
			repeat (3) @(posedge core_clk);
			check({16'h0000, f_en, f_con, f_dp, f_dm},
				{16'h0000, exp_en, exp_con, exp_dp, exp_dm});
			bus(1'b0, HPCL_ADDR_LINE, 32'h0, 4'hF);
			check(rd, line_word());
			bus(1'b0, HPCL_ADDR_REPLY, {30'h0, r[10:9]}, 4'hF);
			check(rd, {8'h00, 8'(chg_word() >> (8 * r[10:9])), 16'h0000});
			wd = rnd();
			bus(1'b1, HPCL_ADDR_CHANGE, wd, r[15:12]);
			for (int p = 0; p < 4; p++) begin
				if (r[12+p]) begin
					exp_en[p] = exp_en[p] & ~wd[8*p+1];
					exp_con[p] = exp_con[p] & ~wd[8*p];
				end
			end
			bus(1'b0, HPCL_ADDR_CHANGE, 32'h0, 4'hF);
			check(rd, chg_word());
		end
		final_report();
	end
endmodule : tb_top
